// ==== sfrse_pkg.sv ====
// Summary of operation
// [RQ1] Hard lock ends only when the write guard pin goes high.
// [RQ2] Quad I/O operation disables hard lock, the guard pin carries data.
// [RQ3] Address bits sampled on clock rise, data driven on clock fall.
// [RQ4] Host sends opcode and 3-byte address, may end read anytime.
// [RQ5] Reads start anywhere, address increments per byte and wraps to zero.
// [RQ6] Fast read takes one dummy byte after the address.
// [RQ7] Fast, dual and quad reads are refused while a write cycle runs.
// [RQ8] Dual read moves address, dummy and data two bits per clock.
// [RQ9] Dual read: opcode, 24-bit address, 4 dummy clocks, then data.
// [RQ10] Host sets the quad enable bit before a quad read.
// [RQ11] Quad read: 24-bit address on four lanes, 6 dummy clocks, data.
// [RQ12] Enhanced quad read: mode byte after address, then 4 dummy clocks.
// [RQ13] Complementary mode byte makes next access start with the address.
// [RQ14] Non-complementary mode byte or standalone FF exits enhanced mode.
// [RQ15] Sector erase sets every bit of the 4K sector to one.
// [RQ16] Host issues write unlock before a sector erase.
// [RQ17] Erase runs only if select rises right after the 24th address bit.
// [RQ18] Address bits 12 and up pick the sector; any sector address is valid.
// [RQ19] Host sends erase as select low, opcode, 3-byte address, select high.
// [RQ20] Erase starts at select rise; busy high throughout, latch clears at end.
// [RQ21] Status stays readable while an erase runs.
// [RQ22] Erase of a block-guarded sector is not executed.
// [RQ23] Host may end a quad read anytime during data by raising select.
// [RQ24] With the write latch clear, erase and status writes are refused; code checks the latch for erase only, config writes ignore it.
// [RQ25] Hard lock holds when status lock bit is one and guard pin low.
// [RQ26] All opcode values are parameters of the command decoder; the FF exit code is the package constant EXIT_CMD instead.
package sfrse_pkg;
  // ==========================================================================
  // Geometry and timing
  localparam int ADDR_W = 24;
  localparam int SECT_LSB = 12;
  localparam int SECT_W = 12;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WIPE_TIME_NS = 45000;
  // Least busy time, so round up
  localparam int WIPE_CYCLES = (WIPE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ==========================================================================
  // Last clock index of each frame field (length minus one), in serial clocks, then the exit opcode
  localparam logic [4:0] CMD_LAST = 5'd7;
  localparam logic [4:0] FAST_DUMMY_LAST = 5'd7;
  localparam logic [4:0] DUAL_DUMMY_LAST = 5'd3;
  localparam logic [4:0] MODE_LAST = 5'd1;
  localparam logic [4:0] ENH_DUMMY_LAST = 5'd3;
  localparam logic [7:0] EXIT_CMD = 8'hff;
  // ==========================================================================
  // Register map and status layout
  localparam logic [31:0] REG_STATUS = 32'h0000_0000;
  localparam logic [31:0] REG_CONFIG = 32'h0000_0004;
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_GUARD = 2;
  localparam int ST_QE = 6;
  localparam int ST_LOCK = 7;
  localparam int ST_HARD = 8;
  localparam int ST_CONT = 9;
  localparam logic [3:0] GUARD_RESET = 4'h0;
  localparam logic QE_RESET = 1'b0;
  localparam logic LOCK_RESET = 1'b0;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_CMD_END, S_ADDR_END, S_IGNORE
  } sfrse_state_type;

  typedef enum logic [2:0] {
    K_READ, K_FAST, K_DUAL, K_QUAD, K_WIPE, K_STATUS
  } sfrse_kind_type;
endpackage

// ==== sfrse_top.sv ====
`timescale 1ns/1ps
module sfrse_top #(
  parameter logic [7:0] OP_READ = 8'h11,
  parameter logic [7:0] OP_FAST = 8'h12,
  parameter logic [7:0] OP_DUAL = 8'h13,
  parameter logic [7:0] OP_QUAD = 8'h14,
  parameter logic [7:0] OP_WIPE = 8'h15,
  parameter logic [7:0] OP_UNLOCK = 8'h16,
  parameter logic [7:0] OP_STATUS = 8'h17,
  parameter int unsigned WIPE_CYCLES = sfrse_pkg::WIPE_CYCLES
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic [3:0] ioLaneIn,
  output logic [3:0] ioLaneOut,
  output logic [3:0] ioLaneOe,
  output logic [23:0] arrayAddr,
  input wire logic [7:0] arrayRdData,
  output logic eraseStrobe,
  output logic [11:0] eraseSector,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  // Assertions share this clock and reset
  default clocking checkClk @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Helpers
  // Sector is guarded when it lies in the top 2^(guard-1) sectors
  function automatic logic isGuarded(input logic [3:0] guard, input logic [11:0] sector);
    logic [12:0] first;
    first = 13'h1000 - (13'h0001 << (guard - 4'h1));
    if (guard == 4'h0) begin
      return 1'b0;
    end
    if (guard >= 4'hd) begin
      return 1'b1;
    end
    return {1'b0, sector} >= first;
  endfunction

  // Last clock of a byte for lane width 1, 2 or 4
  function automatic logic [4:0] byteLast(input logic [1:0] wl);
    return 5'(8 >> wl) - 5'd1;
  endfunction

  logic [5:0] pinMeta_q, pinSync_q, pinPrev_q;
  sfrse_pkg::sfrse_state_type state_q;
  sfrse_pkg::sfrse_kind_type kind_q;
  logic [4:0] clkCnt_q, dataCnt_q;
  logic [1:0] wl_q;
  logic [23:0] shiftIn_q, shiftNext, arrayAddr_q;
  logic [7:0] cmdByte_q, outByte_q, modeByte_q, cmdNext;
  logic loadPending_q, modeValid_q, contMode_q, hardLock_q;
  logic busy_q, writeLatch_q, eraseStrobe_q, eraseGo;
  logic [31:0] wipeCnt_q;
  logic [11:0] eraseSector_q;
  logic [3:0] guard_q, ioLaneOut_q, ioLaneOe_q;
  logic quadEn_q, lock_q;
  logic hreadyout_q, hresp_q, wrPending_q;
  logic [31:0] hrdata_q, wrAddr_q;
  logic [9:0] statusWord;
  logic csN, sclk, csRise, csFall, sclkRise, sclkFall, wpLow;

  // ==========================================================================
  // Pin synchronisers; edges compare the second stage against the third
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pinMeta_q <= 6'h21;
      pinSync_q <= 6'h21;
      pinPrev_q <= 6'h21;
    end else begin
      pinMeta_q <= {chipSelectN, serialClock, ioLaneIn};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  assign csN = pinSync_q[5];
  assign sclk = pinSync_q[4];
  assign csRise = csN & ~pinPrev_q[5];
  assign csFall = ~csN & pinPrev_q[5];
  assign sclkRise = sclk & ~pinPrev_q[4] & ~csN; // RQ3
  assign sclkFall = ~sclk & pinPrev_q[4] & ~csN; // RQ3
  assign wpLow = ~pinSync_q[2];
  assign cmdNext = {shiftIn_q[6:0], pinSync_q[0]};
  assign statusWord = {contMode_q, hardLock_q, lock_q, quadEn_q, guard_q, writeLatch_q, busy_q};

  // Shift in one, two or four lanes per rising edge
  always_comb begin
    unique case (wl_q)
      2'd1: shiftNext = {shiftIn_q[21:0], pinSync_q[1:0]}; // RQ8
      2'd2: shiftNext = {shiftIn_q[19:0], pinSync_q[3:0]}; // RQ11
      default: shiftNext = {shiftIn_q[22:0], pinSync_q[0]};
    endcase
  end

  // ==========================================================================
  // Frame sequencer
  // Select high parks the sequencer, so a frame cut short never leaks into the next
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= sfrse_pkg::S_IDLE;
      kind_q <= sfrse_pkg::K_READ;
      clkCnt_q <= 5'd0;
      wl_q <= 2'd0;
      shiftIn_q <= 24'h000000;
      cmdByte_q <= 8'h00;
    end else if (csN) begin
      state_q <= sfrse_pkg::S_IDLE;
    end else if (csFall) begin
      clkCnt_q <= 5'd0;
      if (contMode_q) begin
        // Opcode-less access, but still refused during a write cycle
        state_q <= busy_q ? sfrse_pkg::S_IGNORE : sfrse_pkg::S_ADDR; // RQ13 RQ7
        kind_q <= sfrse_pkg::K_QUAD;
        wl_q <= 2'd2;
      end else begin
        state_q <= sfrse_pkg::S_CMD;
        wl_q <= 2'd0;
      end
    end else if (sclkRise) begin
      clkCnt_q <= clkCnt_q + 5'd1;
      shiftIn_q <= shiftNext;
      unique case (state_q)
        sfrse_pkg::S_CMD: begin
          if (clkCnt_q == sfrse_pkg::CMD_LAST) begin
            clkCnt_q <= 5'd0;
            cmdByte_q <= cmdNext;
            state_q <= sfrse_pkg::S_ADDR;
            // Opcodes come from parameters
            if (cmdNext == OP_READ) begin // RQ26
              kind_q <= sfrse_pkg::K_READ;
            end else if (cmdNext == OP_FAST) begin
              kind_q <= sfrse_pkg::K_FAST;
              if (busy_q) state_q <= sfrse_pkg::S_IGNORE; // RQ7
            end else if (cmdNext == OP_DUAL) begin
              kind_q <= sfrse_pkg::K_DUAL;
              wl_q <= 2'd1; // RQ8
              if (busy_q) state_q <= sfrse_pkg::S_IGNORE; // RQ7
            end else if (cmdNext == OP_QUAD) begin
              kind_q <= sfrse_pkg::K_QUAD;
              wl_q <= 2'd2; // RQ11
              // Lanes 2 and 3 are only data lanes once quad is enabled
              if (busy_q || !quadEn_q) state_q <= sfrse_pkg::S_IGNORE; // RQ7 RQ10
            end else if (cmdNext == OP_WIPE) begin
              kind_q <= sfrse_pkg::K_WIPE;
            end else if (cmdNext == OP_STATUS) begin
              kind_q <= sfrse_pkg::K_STATUS; // RQ21
              state_q <= sfrse_pkg::S_DATA;
            end else begin
              state_q <= sfrse_pkg::S_CMD_END;
            end
          end
        end
        sfrse_pkg::S_ADDR: begin
          if (clkCnt_q == 5'(24 >> wl_q) - 5'd1) begin
            clkCnt_q <= 5'd0;
            unique case (kind_q)
              sfrse_pkg::K_FAST, sfrse_pkg::K_DUAL: state_q <= sfrse_pkg::S_DUMMY; // RQ6 RQ9
              sfrse_pkg::K_QUAD: state_q <= sfrse_pkg::S_MODE; // RQ12
              sfrse_pkg::K_WIPE: state_q <= sfrse_pkg::S_ADDR_END; // RQ17
              default: state_q <= sfrse_pkg::S_DATA;
            endcase
          end
        end
        sfrse_pkg::S_MODE: begin
          // Mode byte plus 4 dummies make up the 6 quad dummy clocks
          if (clkCnt_q == sfrse_pkg::MODE_LAST) begin // RQ11 RQ12
            clkCnt_q <= 5'd0;
            state_q <= sfrse_pkg::S_DUMMY;
          end
        end
        sfrse_pkg::S_DUMMY: begin
          if (clkCnt_q == ((kind_q == sfrse_pkg::K_FAST) ? sfrse_pkg::FAST_DUMMY_LAST :
              (kind_q == sfrse_pkg::K_DUAL) ? sfrse_pkg::DUAL_DUMMY_LAST : sfrse_pkg::ENH_DUMMY_LAST)) begin // RQ6 RQ9 RQ12
            clkCnt_q <= 5'd0;
            state_q <= sfrse_pkg::S_DATA;
          end
        end
        // Any clock past the byte boundary voids the command
        sfrse_pkg::S_CMD_END, sfrse_pkg::S_ADDR_END: state_q <= sfrse_pkg::S_IGNORE; // RQ17
        default: clkCnt_q <= clkCnt_q;
      endcase
    end
  end

  // ==========================================================================
  // Address counter and data output; the byte is fetched a core cycle ahead
  // of the first falling edge, so serial clock halves must outlast the sync delay
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      arrayAddr_q <= 24'h000000;
      loadPending_q <= 1'b0;
      outByte_q <= 8'h00;
      dataCnt_q <= 5'd0;
      ioLaneOut_q <= 4'h0;
      ioLaneOe_q <= 4'h0;
    end else begin
      if (loadPending_q) begin
        outByte_q <= (kind_q == sfrse_pkg::K_STATUS) ? statusWord[7:0] : arrayRdData; // RQ21
        loadPending_q <= 1'b0;
      end
      if (sclkRise && state_q == sfrse_pkg::S_ADDR && clkCnt_q == 5'(24 >> wl_q) - 5'd1) begin
        arrayAddr_q <= shiftNext; // RQ3 RQ5
        loadPending_q <= 1'b1;
        dataCnt_q <= 5'd0;
      end
      if (sclkRise && state_q == sfrse_pkg::S_CMD && clkCnt_q == sfrse_pkg::CMD_LAST && cmdNext == OP_STATUS) begin
        loadPending_q <= 1'b1;
        dataCnt_q <= 5'd0;
      end
      if (sclkFall && state_q == sfrse_pkg::S_DATA) begin
        unique case (wl_q)
          2'd1: begin
            ioLaneOut_q <= {2'b00, outByte_q[7:6]}; // RQ8
            ioLaneOe_q <= 4'h3;
          end
          2'd2: begin
            ioLaneOut_q <= outByte_q[7:4]; // RQ11
            ioLaneOe_q <= 4'hf;
          end
          default: begin
            ioLaneOut_q <= {2'b00, outByte_q[7], 1'b0}; // RQ3
            ioLaneOe_q <= 4'h2;
          end
        endcase
        outByte_q <= outByte_q << (4'h1 << wl_q);
        dataCnt_q <= dataCnt_q + 5'd1;
        if (dataCnt_q == byteLast(wl_q)) begin
          dataCnt_q <= 5'd0;
          loadPending_q <= 1'b1;
          // Natural 24-bit overflow wraps the counter to zero
          if (kind_q != sfrse_pkg::K_STATUS) arrayAddr_q <= arrayAddr_q + 24'h000001; // RQ5
        end
      end
      if (csN) begin
        ioLaneOe_q <= 4'h0; // RQ4 RQ23
      end
    end
  end

  // ==========================================================================
  // Enhanced quad mode
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      modeByte_q <= 8'h00;
      modeValid_q <= 1'b0;
      contMode_q <= 1'b0;
    end else begin
      if (csFall) modeValid_q <= 1'b0;
      if (sclkRise && state_q == sfrse_pkg::S_MODE && clkCnt_q == sfrse_pkg::MODE_LAST) begin
        modeByte_q <= shiftNext[7:0]; // RQ12
        modeValid_q <= 1'b1;
      end
      // Decision is taken at select rise so an aborted access changes nothing early
      if (csRise) begin
        if (modeValid_q) begin
          contMode_q <= (modeByte_q[7:4] == ~modeByte_q[3:0]); // RQ13 RQ14
        end else if (contMode_q && state_q == sfrse_pkg::S_ADDR && clkCnt_q == 5'd2
                     && shiftIn_q[7:0] == sfrse_pkg::EXIT_CMD) begin
          contMode_q <= 1'b0; // RQ14
        end else if (state_q == sfrse_pkg::S_CMD_END && cmdByte_q == sfrse_pkg::EXIT_CMD) begin
          contMode_q <= 1'b0; // RQ14
        end
      end
    end
  end

  // ==========================================================================
  // Write latch, erase start and self-timed busy cycle
  assign eraseGo = csRise && state_q == sfrse_pkg::S_ADDR_END && kind_q == sfrse_pkg::K_WIPE
                   && writeLatch_q && !busy_q && !isGuarded(guard_q, arrayAddr_q[23:12]); // RQ17 RQ24 RQ22

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      writeLatch_q <= 1'b0;
    end else if (busy_q && wipeCnt_q == 32'h0) begin
      writeLatch_q <= 1'b0; // RQ20
    end else if (csRise && state_q == sfrse_pkg::S_CMD_END && cmdByte_q == OP_UNLOCK && !busy_q) begin
      writeLatch_q <= 1'b1; // RQ16
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      wipeCnt_q <= 32'h0;
      eraseStrobe_q <= 1'b0;
      eraseSector_q <= 12'h000;
    end else begin
      eraseStrobe_q <= eraseGo;
      if (eraseGo) begin
        busy_q <= 1'b1; // RQ20
        wipeCnt_q <= 32'(WIPE_CYCLES - 1);
        // Storage sets the whole 4K sector to ones on this strobe
        eraseSector_q <= arrayAddr_q[23:12]; // RQ15 RQ18
      end else if (busy_q) begin
        if (wipeCnt_q == 32'h0) busy_q <= 1'b0; // RQ20
        else wipeCnt_q <= wipeCnt_q - 32'h1;
      end
    end
  end

  // ==========================================================================
  // Hard lock follows the synchronised guard pin
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hardLock_q <= 1'b0;
    end else if (quadEn_q) begin
      hardLock_q <= 1'b0; // RQ2
    end else if (lock_q && wpLow) begin
      hardLock_q <= 1'b1; // RQ25
    end else if (!wpLow) begin
      hardLock_q <= 1'b0; // RQ1
    end
  end

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      hrdata_q <= 32'h0;
      wrPending_q <= 1'b0;
      wrAddr_q <= 32'h0;
    end else begin
      wrPending_q <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wrPending_q <= hwrite;
        wrAddr_q <= haddr;
        if (!hwrite) begin
          if (haddr == sfrse_pkg::REG_STATUS) hrdata_q <= {22'h0, statusWord}; // RQ21
          else if (haddr == sfrse_pkg::REG_CONFIG) hrdata_q <= {24'h0, lock_q, quadEn_q, guard_q, 2'b00};
          else hrdata_q <= 32'h0;
        end
      end
    end
  end

  // Configuration writes are dropped while hard lock holds
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      guard_q <= sfrse_pkg::GUARD_RESET;
      quadEn_q <= sfrse_pkg::QE_RESET;
      lock_q <= sfrse_pkg::LOCK_RESET;
    end else if (wrPending_q && wrAddr_q == sfrse_pkg::REG_CONFIG && !hardLock_q) begin // RQ1 RQ25
      guard_q <= hwdata[sfrse_pkg::ST_GUARD +: 4];
      quadEn_q <= hwdata[sfrse_pkg::ST_QE];
      lock_q <= hwdata[sfrse_pkg::ST_LOCK];
    end
  end

  assign ioLaneOut = ioLaneOut_q;
  assign ioLaneOe = ioLaneOe_q;
  assign arrayAddr = arrayAddr_q;
  assign eraseStrobe = eraseStrobe_q;
  assign eraseSector = eraseSector_q;
  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;

  // ==========================================================================
  // Checks
  property p_busyRejectFast;
    sclkRise && state_q == sfrse_pkg::S_CMD && clkCnt_q == 5'd7 && cmdNext == OP_FAST && busy_q
    |=> state_q == sfrse_pkg::S_IGNORE;
  endproperty
  a_busyRejectFast: assert property (p_busyRejectFast) else $error("fast read taken while busy"); // RQ7

  property p_eraseStart;
    eraseGo |=> busy_q && eraseStrobe_q && eraseSector == $past(arrayAddr_q[23:12]);
  endproperty
  a_eraseStart: assert property (p_eraseStart) else $error("erase did not start"); // RQ20

  property p_busyEnd;
    $fell(busy_q) |-> !writeLatch_q;
  endproperty
  a_busyEnd: assert property (p_busyEnd) else $error("latch kept after erase"); // RQ20

  property p_noLatch;
    csRise && state_q == sfrse_pkg::S_ADDR_END && !writeLatch_q && !busy_q |=> !busy_q [*2];
  endproperty
  a_noLatch: assert property (p_noLatch) else $error("erase without latch"); // RQ24

  property p_guarded;
    csRise && state_q == sfrse_pkg::S_ADDR_END && isGuarded(guard_q, arrayAddr_q[23:12]) && !busy_q
    |=> !busy_q && !eraseStrobe_q;
  endproperty
  a_guarded: assert property (p_guarded) else $error("guarded sector erased"); // RQ22

  property p_boundary;
    csRise && kind_q == sfrse_pkg::K_WIPE && state_q != sfrse_pkg::S_ADDR_END && !busy_q |=> !busy_q;
  endproperty
  a_boundary: assert property (p_boundary) else $error("erase off byte boundary"); // RQ17

  property p_lockHolds;
    hardLock_q && wrPending_q && wrAddr_q == sfrse_pkg::REG_CONFIG |=> $stable(guard_q) && $stable(lock_q);
  endproperty
  a_lockHolds: assert property (p_lockHolds) else $error("config changed in hard lock"); // RQ1

  property p_quadNoLock;
    quadEn_q |=> !hardLock_q;
  endproperty
  a_quadNoLock: assert property (p_quadNoLock) else $error("hard lock in quad mode"); // RQ2

  property p_addrWrap;
    sclkFall && state_q == sfrse_pkg::S_DATA && kind_q != sfrse_pkg::K_STATUS
    && arrayAddr_q == 24'hffffff && dataCnt_q == byteLast(wl_q) |=> arrayAddr_q == 24'h000000;
  endproperty
  a_addrWrap: assert property (p_addrWrap) else $error("address did not wrap"); // RQ5

  property p_oeIdle;
    csN |=> ioLaneOe_q == 4'h0;
  endproperty
  a_oeIdle: assert property (p_oeIdle) else $error("lane driven while deselected"); // RQ4 RQ23

  property p_contEnter;
    csRise && modeValid_q && modeByte_q[7:4] == ~modeByte_q[3:0] |=> contMode_q;
  endproperty
  a_contEnter: assert property (p_contEnter) else $error("enhanced mode not entered"); // RQ13

  property p_contExit;
    csRise && modeValid_q && modeByte_q[7:4] != ~modeByte_q[3:0] |=> !contMode_q;
  endproperty
  a_contExit: assert property (p_contExit) else $error("enhanced mode not left"); // RQ14

  property p_dualLanes;
    sclkFall && state_q == sfrse_pkg::S_DATA && wl_q == 2'd1 |=> ioLaneOe_q == 4'h3;
  endproperty
  a_dualLanes: assert property (p_dualLanes) else $error("dual data not on two lanes"); // RQ8
endmodule

// ==== sfrse_host_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Host controller model: select, serial clock and lane drive
module sfrse_host_model (
  input wire logic core_clk,
  input wire logic guardPin,
  input wire logic [3:0] ioLaneOut,
  input wire logic [3:0] ioLaneOe,
  output logic chipSelectN,
  output logic serialClock,
  output logic [3:0] ioLaneIn
);
  logic [3:0] hostVal = 4'h0;
  logic [3:0] hostOe = 4'h0;
  // Clock rests low and select high outside frames
  initial begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
  end
  // Released lanes show the inverted stale bit, lane2 the guard pin
  assign ioLaneIn = (ioLaneOe & ioLaneOut) | (~ioLaneOe & hostOe & hostVal)
    | (~ioLaneOe & ~hostOe & {~hostVal[3], guardPin, ~hostVal[1:0]});
  // Select edge plus a gap above the least deselect time
  task cs(input logic v);
    chipSelectN <= v;
    if (v) hostOe <= 4'h0;
    repeat (8) @(posedge core_clk);
  endtask
  // MSB first, set while the clock is low, taken on the rise
  task go(input logic [31:0] v, input int n, input int w);
    for (int i = n - 1; i >= 0; i--) begin
      hostVal <= (w == 1) ? {3'h0, v[i]} : (w == 2) ? {2'h0, v[2*i+:2]} : v[4*i+:4];
      hostOe <= (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
      repeat (8) @(posedge core_clk);
      serialClock <= 1'b1;
      repeat (8) @(posedge core_clk);
      serialClock <= 1'b0;
    end
  endtask
  // Data taken before each rise, long after the launching fall
  task get(output logic [31:0] v, input int n, input int w);
    v = 32'h0;
    hostOe <= 4'h0;
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge core_clk);
      v = (w == 1) ? {v[30:0], ioLaneIn[1]} : (w == 2) ? {v[29:0], ioLaneIn[1:0]} : {v[27:0], ioLaneIn};
      serialClock <= 1'b1;
      repeat (8) @(posedge core_clk);
      serialClock <= 1'b0;
    end
  endtask
endmodule

// ==== serial_flash_read_and_sector_erase_tb_top.sv ====
`timescale 1ns/1ps
module serial_flash_read_and_sector_erase_tb_top;
  typedef struct {logic [7:0] op; int w; logic [23:0] a; int dummy;} sfrse_row_type;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic guardPin = 1'b0;
  logic chipSelectN, serialClock, eraseStrobe, hreadyout, hresp;
  logic [3:0] ioLaneIn, ioLaneOut, ioLaneOe, oeSeen;
  logic [23:0] arrayAddr;
  logic [11:0] eraseSector, lastSector;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  int error_cnt = 0;
  int samples_checked = 0;
  int strobes = 0;
  // Design default opcodes; the dual row wraps past the top address
  sfrse_row_type rows [4] = '{'{8'h11, 1, 24'h123456, 0}, '{8'h12, 1, 24'habcdef, 8},
    '{8'h13, 2, 24'hffffff, 4}, '{8'h14, 4, 24'h0f0f0f, 4}};
  // Storage pattern
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
  endfunction
  // ==========================================================
  // Clock, design and host
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  sfrse_top #(.WIPE_CYCLES(2000)) i_sfrse_top (.core_clk(core_clk), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .ioLaneIn(ioLaneIn), .ioLaneOut(ioLaneOut), .ioLaneOe(ioLaneOe),
    .arrayAddr(arrayAddr), .arrayRdData(mem(arrayAddr)), .eraseStrobe(eraseStrobe), .eraseSector(eraseSector),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  sfrse_host_model i_sfrse_host_model (.core_clk(core_clk), .guardPin(guardPin), .ioLaneOut(ioLaneOut),
    .ioLaneOe(ioLaneOe), .chipSelectN(chipSelectN), .serialClock(serialClock), .ioLaneIn(ioLaneIn));
  // Gather erase pulses and lane drive
  always @(posedge core_clk) begin
    if (eraseStrobe === 1'b1) begin
      strobes++;
      lastSector = eraseSector;
    end
    oeSeen = oeSeen | ioLaneOe;
  end
  // ==========================================================
  // Checking and bus tasks
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Bounded wait for hready
  task waitRdy();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        chk("bus wait", 0, 1);
        stop_test();
      end
      @(posedge core_clk);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask
  // Read frame; quad carries a mode byte after the address
  task frame(input logic [7:0] op, input bit useOp, input int w, input logic [23:0] a, input logic [7:0] m,
    input int dummy);
    i_sfrse_host_model.cs(1'b0);
    oeSeen = 4'h0;
    if (useOp) i_sfrse_host_model.go({24'h0, op}, 8, 1);
    i_sfrse_host_model.go({8'h0, a}, 24 / w, w);
    if (w == 4) i_sfrse_host_model.go({24'h0, m}, 2, 4);
    i_sfrse_host_model.go(32'h0, dummy, w);
    i_sfrse_host_model.get(rd, 16 / w, w);
    i_sfrse_host_model.cs(1'b1);
  endtask
  task cmd(input logic [7:0] op, input int n, input logic [31:0] a, input int r);
    i_sfrse_host_model.cs(1'b0);
    i_sfrse_host_model.go({24'h0, op}, 8, 1);
    i_sfrse_host_model.go(a, n, 1);
    i_sfrse_host_model.get(rd, r, 1);
    i_sfrse_host_model.cs(1'b1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    ahb(0, sfrse_pkg::REG_STATUS, 0);
    chk("status reset", rd, 0);
    chk("hreadyout", 32'(hreadyout), 1);
    $display("test reset done");
    // Hard lock freezes config until the guard pin rises
    ahb(1, sfrse_pkg::REG_CONFIG, 32'h80);
    ahb(0, sfrse_pkg::REG_STATUS, 0);
    chk("hard lock", 32'(rd[8:7]), 3);
    ahb(1, sfrse_pkg::REG_CONFIG, 32'h3c);
    ahb(0, sfrse_pkg::REG_CONFIG, 0);
    chk("locked config", rd, 32'h80);
    guardPin <= 1'b1;
    repeat (6) @(posedge core_clk);
    ahb(0, sfrse_pkg::REG_STATUS, 0);
    chk("lock released", 32'(rd[8]), 0);
    ahb(1, sfrse_pkg::REG_CONFIG, 32'h40);
    $display("test hard lock done");
    foreach (rows[i]) begin
      frame(rows[i].op, 1, rows[i].w, rows[i].a, 8'h00, rows[i].dummy);
      chk("read data", rd, {16'h0, mem(rows[i].a), mem(rows[i].a + 24'h1)});
    end
    $display("test read rows done");
    frame(8'h14, 1, 4, 24'h000100, 8'ha5, 4);
    chk("enhanced data", rd, {16'h0, mem(24'h100), mem(24'h101)});
    ahb(0, sfrse_pkg::REG_STATUS, 0);
    chk("enhanced on", 32'(rd[9]), 1);
    frame(8'h00, 0, 4, 24'h02a0ff, 8'h55, 4);
    chk("no-opcode data", rd, {16'h0, mem(24'h02a0ff), mem(24'h02a100)});
    ahb(0, sfrse_pkg::REG_STATUS, 0);
    chk("enhanced off", 32'(rd[9]), 0);
    $display("test enhanced done");
    cmd(8'h16, 0, 0, 0);
    cmd(8'h15, 24, 32'h345678, 0);
    ahb(0, sfrse_pkg::REG_STATUS, 0);
    chk("busy and latch", 32'(rd[1:0]), 3);
    chk("erase sector", {20'h0, lastSector}, 32'h345);
    frame(8'h12, 1, 1, 24'h0, 8'h00, 8);
    chk("refused fast read", 32'(oeSeen), 0);
    cmd(8'h17, 0, 0, 8);
    chk("status byte", rd, 32'h43);
    for (int n = 0; n < 1000 && rd[0] !== 1'b0; n++) begin
      ahb(0, sfrse_pkg::REG_STATUS, 0);
    end
    chk("erase done", 32'(rd[1:0]), 0);
    $display("test erase done");
    // Refused erases: no latch, one bit past the boundary, guarded top sector
    for (int k = 0; k < 3; k++) begin
      if (k == 2) ahb(1, sfrse_pkg::REG_CONFIG, 32'h44);
      if (k > 0) cmd(8'h16, 0, 0, 0);
      cmd(8'h15, (k == 1) ? 25 : 24, 32'hffffff, 0);
      ahb(0, sfrse_pkg::REG_STATUS, 0);
      chk("refused erase", 32'(rd[0]), 0);
    end
    chk("strobe count", strobes, 1);
    $display("test refused erase done");
    stop_test();
  end
endmodule
